/* File: design/ppc_pkg.sv */
package ppc_pkg;

   localparam int NPORT = 4;

   // command codes of the register file
   localparam logic [7:0] CMD_MODE     = 8'h12;
   localparam logic [7:0] CMD_DISC_EN  = 8'h13;
   localparam logic [7:0] CMD_DC_EN    = 8'h14;
   localparam logic [7:0] CMD_TIMING   = 8'h16;
   localparam logic [7:0] CMD_MASK     = 8'h17;
   localparam logic [7:0] CMD_RESTART  = 8'h18;
   localparam logic [7:0] CMD_PWR_CMD  = 8'h19;

   // field positions
   localparam int MASK_GLOBAL_INTERRUPT_ENABLE_BIT  = 7;
   localparam int MASK_OSCILLATOR_FAULT_MASK_BIT = 5;
   localparam int TIM_START_LSB   = 4;
   localparam int TIM_OVERCURRENT_CUT_THRESHOLD_LSB    = 2;
   localparam int TIM_DIS_LSB     = 0;
   localparam int HI_NIB_LSB      = 4;

   // values after reset
   localparam logic [7:0] TIMING_RST = 8'h00;
   localparam logic       GLOBAL_INTERRUPT_ENABLE_RST  = 1'b1;
   localparam logic       OSCILLATOR_FAULT_MASK_RST = 1'b1;
   localparam logic [3:0] DC_DISCONNECT_ENABLE_RST   = 4'h0;
   localparam logic [7:0] RDATA_RST  = 8'h00;
   localparam logic [1:0] INIT_LOAD  = 2'h2;

   // port mode encodings
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_MANUAL = 2'h1;
   localparam logic [1:0] MODE_SEMI   = 2'h2;
   localparam logic [1:0] MODE_AUTO   = 2'h3;

   // timing
   localparam int CLK_NS        = 20;
   localparam int MS_NS         = 1000000;
   localparam int TICK_CYCLES   = MS_NS / CLK_NS;
   localparam int MPDO_MS       = 300;
   localparam int DC_HOLD_PCT   = 17;
   localparam int DC_HOLD_MS    = (MPDO_MS * DC_HOLD_PCT + 99) / 100;
   localparam int OC_UP_STEP    = 16;
   localparam int OC_DOWN_STEP  = 1;

   // per-port analog sense bundle
   typedef struct packed {
      logic ac_imp_high;
      logic dc_cur_low;
      logic over_cut;
      logic foldback;
      logic det_done;
      logic det_valid;
      logic cls_done;
   } ppc_sense_t;

   // register access from the serial management slave
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } ppc_reg_req_t;

   // start and overcurrent fault time in ms
   function automatic logic [7:0] fault_ms(input logic [1:0] sel);
      unique case (sel)
         2'h0: fault_ms = 8'h3C;
         2'h1: fault_ms = 8'h1E;
         2'h2: fault_ms = 8'h78;
         2'h3: fault_ms = 8'hF0;
      endcase
   endfunction

   // disconnect delay in ms
   function automatic logic [9:0] dis_ms(input logic [1:0] sel);
      unique case (sel)
         2'h0: dis_ms = 10'h168;
         2'h1: dis_ms = 10'h05A;
         2'h2: dis_ms = 10'h0B4;
         2'h3: dis_ms = 10'h2D0;
      endcase
   endfunction

endpackage

/* File: design/ppc_port_timers.sv */
`timescale 1ns/1ns
module ppc_port_timers
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // time base and port state
   input  wire logic       tick_i,
   input  wire logic       power_i,
   input  wire ppc_sense_t sense_i,
   // configuration
   input  wire logic       ac_en_i,
   input  wire logic       dc_en_i,
   input  wire logic [7:0] start_ms_i,
   input  wire logic [7:0] overcurrent_cut_threshold_ms_i,
   input  wire logic [9:0] dis_ms_i,
   // trips and cooldown
   output logic            start_trip_o,
   output logic            oc_trip_o,
   output logic            dis_trip_o,
   output logic            cooldown_o
);

   logic [7:0]  start_cnt_r;
   logic [7:0]  start_cnt_nxt;
   logic [11:0] oc_cnt_r;
   logic [11:0] oc_cnt_nxt;
   logic [9:0]  dis_cnt_r;
   logic [9:0]  dis_cnt_nxt;
   logic [7:0]  hold_cnt_r;
   logic [7:0]  hold_cnt_nxt;

   wire         in_start   = power_i && (start_cnt_r < start_ms_i);
   wire [11:0]  oc_limit   = {overcurrent_cut_threshold_ms_i, 4'h0};
   wire [11:0]  oc_up      = oc_cnt_r + 12'(OC_UP_STEP);
   wire         oc_inc     = tick_i && power_i && !in_start && sense_i.over_cut;
   wire         oc_dec     = tick_i && (oc_cnt_r != 12'h000) &&
                             (!power_i || (!sense_i.over_cut && !sense_i.foldback));
   wire         dc_restore = hold_cnt_r >= 8'(DC_HOLD_MS);
   wire         dis_cond   = (ac_en_i && sense_i.ac_imp_high) ||
                             (dc_en_i && sense_i.dc_cur_low);
   wire         dis_clear  = !dis_cond && (!dc_en_i || dc_restore);

   // inrush overcurrent still present when the start window closes
   assign start_trip_o = tick_i && power_i && sense_i.over_cut &&
                         (start_cnt_r == start_ms_i - 8'h01);
   assign oc_trip_o    = oc_inc && (oc_up >= oc_limit);
   // only an enabled method can raise the condition
   assign dis_trip_o   = tick_i && power_i && dis_cond &&
                         (dis_cnt_r == dis_ms_i - 10'h001);
   assign cooldown_o   = oc_cnt_r != 12'h000;

   assign start_cnt_nxt = !power_i ? 8'h00 :
                          (tick_i && in_start) ? start_cnt_r + 8'h01 : start_cnt_r;

   // up by 16 per ms, down by 1 per ms, floor at zero; keeps running while off
   assign oc_cnt_nxt = start_trip_o ? {start_ms_i, 4'h0} :
                       oc_inc ? ((oc_up >= oc_limit) ? oc_limit : oc_up) :
                       oc_dec ? oc_cnt_r - 12'(OC_DOWN_STEP) : oc_cnt_r;

   // dc current must stay above threshold for the hold time before the timer clears
   assign hold_cnt_nxt = sense_i.dc_cur_low ? 8'h00 :
                         (tick_i && !dc_restore) ? hold_cnt_r + 8'h01 : hold_cnt_r;

   assign dis_cnt_nxt = !power_i ? 10'h000 :
                        dis_clear ? 10'h000 :
                        (dis_cond && tick_i) ? dis_cnt_r + 10'h001 : dis_cnt_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_cnt_r <= 8'h00;
         oc_cnt_r    <= 12'h000;
         dis_cnt_r   <= 10'h000;
         hold_cnt_r  <= 8'h00;
      end else begin
         start_cnt_r <= start_cnt_nxt;
         oc_cnt_r    <= oc_cnt_nxt;
         dis_cnt_r   <= dis_cnt_nxt;
         hold_cnt_r  <= hold_cnt_nxt;
      end
   end

endmodule

/* File: design/pse_port_control_regs.sv */
`timescale 1ns/1ns
module pse_port_control_regs
   import ppc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   // configuration pin
   input  wire logic                   auto_pin_i,
   // register access
   input  wire ppc_reg_req_t           reg_req_i,
   output logic [7:0]                  reg_rdata_o,
   // analog port sensing
   input  wire ppc_sense_t [NPORT-1:0] sense_i,
   input  wire logic                   osc_invalid_i,
   // interrupt source from the event logic
   input  wire logic                   int_pending_i,
   // port control
   output logic [NPORT-1:0]            port_power_o,
   output logic [NPORT-1:0]            detect_req_o,
   output logic [NPORT-1:0]            class_req_o,
   output logic [NPORT-1:0]            disconnect_fault_flag_o,
   output logic                        oscillator_fault_flag_o,
   output logic                        int_o
);

   // reset release and pin synchronisers
   logic                   rst_s1_r;
   logic                   rst_s2_r;
   logic                   auto_s1_r;
   logic                   auto_s2_r;
   logic                   osc_s1_r;
   logic                   osc_s2_r;
   ppc_sense_t [NPORT-1:0] sense_s1_r;
   ppc_sense_t [NPORT-1:0] sense_s2_r;
   logic [1:0]             init_cnt_r;
   logic [1:0]             init_cnt_nxt;

   // registers
   logic [7:0]             mode_r;
   logic [7:0]             mode_nxt;
   logic [3:0]             ac_disconnect_enable_r;
   logic [3:0]             ac_disconnect_enable_nxt;
   logic [3:0]             dc_disconnect_enable_r;
   logic [3:0]             dc_disconnect_enable_nxt;
   logic [3:0]             detection_enable_r;
   logic [3:0]             detection_enable_nxt;
   logic [3:0]             cle_r;
   logic [3:0]             cle_nxt;
   logic [7:0]             timing_r;
   logic [7:0]             timing_nxt;
   logic                   global_interrupt_enable_r;
   logic                   global_interrupt_enable_nxt;
   logic                   oscillator_fault_mask_r;
   logic                   oscillator_fault_mask_nxt;
   logic [7:0]             rdata_r;
   logic [7:0]             rdata_nxt;

   // port state
   logic [3:0]             power_r;
   logic [3:0]             power_nxt;
   logic [3:0]             disf_r;
   logic [3:0]             disf_nxt;
   logic                   oscillator_fault_flag_r;
   logic                   oscillator_fault_flag_nxt;
   logic [15:0]            tick_cnt_r;
   logic [15:0]            tick_cnt_nxt;

   wire                    rst_sync_n = rst_s2_r;
   wire                    init_done  = init_cnt_r == 2'h3;
   wire                    load_auto  = init_cnt_r == INIT_LOAD;
   wire                    tick       = tick_cnt_r == 16'(TICK_CYC - 1);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         auto_s1_r  <= 1'b0;
         auto_s2_r  <= 1'b0;
         osc_s1_r   <= 1'b0;
         osc_s2_r   <= 1'b0;
         sense_s1_r <= '0;
         sense_s2_r <= '0;
      end else begin
         auto_s1_r  <= auto_pin_i;
         auto_s2_r  <= auto_s1_r;
         osc_s1_r   <= osc_invalid_i;
         osc_s2_r   <= osc_s1_r;
         sense_s1_r <= sense_i;
         sense_s2_r <= sense_s1_r;
      end
   end

   // register decode
   wire       wr_ok      = reg_req_i.wr && init_done;
   wire       wr_mode    = wr_ok && (reg_req_i.cmd == CMD_MODE);
   wire       wr_disc    = wr_ok && (reg_req_i.cmd == CMD_DISC_EN);
   wire       wr_dcen    = wr_ok && (reg_req_i.cmd == CMD_DC_EN);
   wire       wr_timing  = wr_ok && (reg_req_i.cmd == CMD_TIMING);
   wire       wr_mask    = wr_ok && (reg_req_i.cmd == CMD_MASK);
   wire       wr_restart = wr_ok && (reg_req_i.cmd == CMD_RESTART);
   wire       wr_pwr     = wr_ok && (reg_req_i.cmd == CMD_PWR_CMD);
   wire [7:0] wd         = reg_req_i.wdata;
   wire [3:0] wd_hi      = wd[HI_NIB_LSB +: 4];
   wire [3:0] wd_lo      = wd[3:0];

   // write-only registers act as one-cycle strobes and store nothing
   wire [3:0] rst_cls    = wr_restart ? wd_hi : 4'h0;
   wire [3:0] rst_det    = wr_restart ? wd_lo : 4'h0;
   wire [3:0] cmd_off    = wr_pwr ? wd_hi : 4'h0;
   wire [3:0] cmd_on     = wr_pwr ? wd_lo : 4'h0;

   // shared timing selections
   wire [7:0] start_ms   = fault_ms(timing_r[TIM_START_LSB +: 2]);
   wire [7:0] overcurrent_cut_threshold_ms    = fault_ms(timing_r[TIM_OVERCURRENT_CUT_THRESHOLD_LSB +: 2]);
   wire [9:0] dis_dly_ms = dis_ms(timing_r[TIM_DIS_LSB +: 2]);

   // per-port mode decode and power control
   logic [3:0] is_off;
   logic [3:0] is_manual;
   logic [3:0] is_auto;
   logic [3:0] start_trip;
   logic [3:0] oc_trip;
   logic [3:0] dis_trip;
   logic [3:0] cooldown;
   logic [3:0] off_evt;
   logic [3:0] on_evt;

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      wire [1:0] pm = mode_r[2*p +: 2];

      assign is_off[p]    = pm == MODE_OFF;
      assign is_manual[p] = pm == MODE_MANUAL;
      assign is_auto[p]   = pm == MODE_AUTO;

      // off wins when both commands land in one write
      assign off_evt[p] = is_off[p] || cmd_off[p] ||
                          start_trip[p] || oc_trip[p] || dis_trip[p];
      // only auto mode powers on by itself after a valid classified load
      assign on_evt[p]  = cmd_on[p] ||
                          (is_auto[p] && sense_s2_r[p].cls_done &&
                           sense_s2_r[p].det_valid);

      ppc_port_timers u_timers (
         .clk_i        (clk_i),
         .rst_n_i      (rst_sync_n),
         .tick_i       (tick),
         .power_i      (power_r[p]),
         .sense_i      (sense_s2_r[p]),
         .ac_en_i      (ac_disconnect_enable_r[p]),
         .dc_en_i      (dc_disconnect_enable_r[p]),
         .start_ms_i   (start_ms),
         .overcurrent_cut_threshold_ms_i    (overcurrent_cut_threshold_ms),
         .dis_ms_i     (dis_dly_ms),
         .start_trip_o (start_trip[p]),
         .oc_trip_o    (oc_trip[p]),
         .dis_trip_o   (dis_trip[p]),
         .cooldown_o   (cooldown[p])
      );
   end

   // power on refused while the fault counter cools down
   assign power_nxt = (power_r & ~off_evt) |
                      (on_evt & ~off_evt & ~cooldown);

   // set wins over the clear by a power-off command
   assign disf_nxt  = (disf_r & ~cmd_off) | dis_trip;

   // manual completion clears its own bit; restart sets wins over clears
   wire [3:0] det_clr = (is_manual & {sense_s2_r[3].det_done, sense_s2_r[2].det_done,
                                      sense_s2_r[1].det_done, sense_s2_r[0].det_done})
                        | cmd_off;
   wire [3:0] cls_clr = (is_manual & {sense_s2_r[3].cls_done, sense_s2_r[2].cls_done,
                                      sense_s2_r[1].cls_done, sense_s2_r[0].cls_done})
                        | cmd_off;

   assign detection_enable_nxt = load_auto ? {4{auto_s2_r}} :
                     ((wr_dcen ? wd_lo : detection_enable_r) & ~det_clr) | rst_det;
   assign cle_nxt  = load_auto ? {4{auto_s2_r}} :
                     ((wr_dcen ? wd_hi : cle_r) & ~cls_clr) | rst_cls;

   assign mode_nxt   = load_auto ? {8{auto_s2_r}} :
                       wr_mode ? wd : mode_r;
   assign ac_disconnect_enable_nxt   = load_auto ? {4{auto_s2_r}} :
                       wr_disc ? wd_hi : ac_disconnect_enable_r;
   assign dc_disconnect_enable_nxt   = wr_disc ? wd_lo : dc_disconnect_enable_r;
   assign timing_nxt = wr_timing ? wd : timing_r;
   assign global_interrupt_enable_nxt  = wr_mask ? wd[MASK_GLOBAL_INTERRUPT_ENABLE_BIT] : global_interrupt_enable_r;
   assign oscillator_fault_mask_nxt = wr_mask ? wd[MASK_OSCILLATOR_FAULT_MASK_BIT] : oscillator_fault_mask_r;

   // masked oscillator never raises the flag
   assign oscillator_fault_flag_nxt = oscillator_fault_mask_r && osc_s2_r;

   assign init_cnt_nxt = init_done ? init_cnt_r : init_cnt_r + 2'h1;
   assign tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;

   // read mux; write-only and unmapped codes read zero
   logic [7:0] rd_mux;
   always_comb begin
      unique case (reg_req_i.cmd)
         CMD_MODE:    rd_mux = mode_r;
         CMD_DISC_EN: rd_mux = {ac_disconnect_enable_r, dc_disconnect_enable_r};
         CMD_DC_EN:   rd_mux = {cle_r, detection_enable_r};
         CMD_TIMING:  rd_mux = {2'h0, timing_r[5:0]};
         CMD_MASK:    rd_mux = {global_interrupt_enable_r, 1'b0, oscillator_fault_mask_r, 5'h00};
         default:     rd_mux = 8'h00;
      endcase
   end
   assign rdata_nxt = reg_req_i.rd ? rd_mux : rdata_r;

   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         init_cnt_r <= 2'h0;
         mode_r     <= 8'h00;
         ac_disconnect_enable_r     <= 4'h0;
         dc_disconnect_enable_r     <= DC_DISCONNECT_ENABLE_RST;
         detection_enable_r     <= 4'h0;
         cle_r      <= 4'h0;
         timing_r   <= TIMING_RST;
         global_interrupt_enable_r    <= GLOBAL_INTERRUPT_ENABLE_RST;
         oscillator_fault_mask_r   <= OSCILLATOR_FAULT_MASK_RST;
         rdata_r    <= RDATA_RST;
      end else begin
         init_cnt_r <= init_cnt_nxt;
         mode_r     <= mode_nxt;
         ac_disconnect_enable_r     <= ac_disconnect_enable_nxt;
         dc_disconnect_enable_r     <= dc_disconnect_enable_nxt;
         detection_enable_r     <= detection_enable_nxt;
         cle_r      <= cle_nxt;
         timing_r   <= timing_nxt;
         global_interrupt_enable_r    <= global_interrupt_enable_nxt;
         oscillator_fault_mask_r   <= oscillator_fault_mask_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         power_r    <= 4'h0;
         disf_r     <= 4'h0;
         oscillator_fault_flag_r     <= 1'b0;
         tick_cnt_r <= 16'h0000;
      end else begin
         power_r    <= power_nxt;
         disf_r     <= disf_nxt;
         oscillator_fault_flag_r     <= oscillator_fault_flag_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   assign reg_rdata_o             = rdata_r;
   assign port_power_o            = power_r;
   assign disconnect_fault_flag_o = disf_r;
   assign oscillator_fault_flag_o = oscillator_fault_flag_r;
   // no port is serialised against another, so all may classify at once
   assign detect_req_o = detection_enable_r & ~is_off & ~power_r;
   assign class_req_o  = cle_r & ~is_off & ~power_r;
   assign int_o        = global_interrupt_enable_r && int_pending_i;

endmodule

/* File: sim/ppc_checker_properties.sv */
`timescale 1ns/1ns
module ppc_checker
   import ppc_pkg::*;
(
   // clock and reset
   input wire logic             clk_i,
   input wire logic             rst_n_i,
   // register access
   input wire ppc_reg_req_t     reg_req_i,
   input wire logic [7:0]       reg_rdata_o,
   // sense and interrupt source
   input wire logic             osc_invalid_i,
   input wire logic             int_pending_i,
   // port control
   input wire logic [NPORT-1:0] port_power_o,
   input wire logic [NPORT-1:0] detect_req_o,
   input wire logic [NPORT-1:0] class_req_o,
   input wire logic [NPORT-1:0] disconnect_fault_flag_o,
   input wire logic             oscillator_fault_flag_o,
   input wire logic             int_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   wire             wr_q = reg_req_i.wr;
   wire             rd_q = reg_req_i.rd;
   wire             pwr_wr = wr_q && (reg_req_i.cmd == CMD_PWR_CMD);
   wire [NPORT-1:0] off_cmd = pwr_wr ? reg_req_i.wdata[7:4] : 4'h0;

   property p_rd_restart;
      rd_q && reg_req_i.cmd == CMD_RESTART |=> reg_rdata_o == 8'h00;
   endproperty
   a_rd_restart: assert property (p_rd_restart) else $error("restart read not zero");
   property p_rd_timing;
      rd_q && reg_req_i.cmd == CMD_TIMING |=> reg_rdata_o[7:6] == 2'h0;
   endproperty
   a_rd_timing: assert property (p_rd_timing) else $error("timing spare bits set");
   property p_rd_mask;
      rd_q && reg_req_i.cmd == CMD_MASK |=> (reg_rdata_o & 8'h5F) == 8'h00;
   endproperty
   a_rd_mask: assert property (p_rd_mask) else $error("mask spare bits set");
   property p_off_cmd;
      off_cmd != 4'h0 |=> (port_power_o & $past(off_cmd)) == 4'h0;
   endproperty
   a_off_cmd: assert property (p_off_cmd) else $error("port on after off command");
   property p_mode_off;
      wr_q && reg_req_i.cmd == CMD_MODE && reg_req_i.wdata == 8'h00
         |-> ##2 (port_power_o | detect_req_o | class_req_o) == 4'h0;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("activity in off mode");
   property p_int_mask;
      wr_q && reg_req_i.cmd == CMD_MASK && !reg_req_i.wdata[7] |=> !int_o;
   endproperty
   a_int_mask: assert property (p_int_mask) else $error("interrupt with enable low");
   property p_int_src;
      int_o |-> int_pending_i;
   endproperty
   a_int_src: assert property (p_int_src) else $error("interrupt without source");
   property p_osc_flag;
      oscillator_fault_flag_o |-> $past(osc_invalid_i, 2) || $past(osc_invalid_i, 3)
         || $past(osc_invalid_i, 4);
   endproperty
   a_osc_flag: assert property (p_osc_flag) else $error("oscillator flag without fault");
   property p_disf_trip;
      (disconnect_fault_flag_o & ~$past(disconnect_fault_flag_o)) != 4'h0
         |-> ##[0:1] (port_power_o & disconnect_fault_flag_o) == 4'h0;
   endproperty
   a_disf_trip: assert property (p_disf_trip) else $error("port on after disconnect");

   c_disf: cover property (disconnect_fault_flag_o != 4'h0);
   c_all_cls: cover property (class_req_o == 4'hF);
   c_int: cover property (int_o);
endmodule

bind pse_port_control_regs ppc_checker chk_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
   .osc_invalid_i(osc_invalid_i), .int_pending_i(int_pending_i), .port_power_o(port_power_o),
   .detect_req_o(detect_req_o), .class_req_o(class_req_o),
   .disconnect_fault_flag_o(disconnect_fault_flag_o),
   .oscillator_fault_flag_o(oscillator_fault_flag_o), .int_o(int_o)
);

/* File: sim/ppc_host_model.sv */
`timescale 1ns/1ns
module ppc_host_model
   import ppc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output ppc_reg_req_t    req_o
);
   initial req_o = '0;

   // one command code and one data byte per access, released bus shows inverted code
   task automatic wr_reg(input logic [7:0] c, input logic [7:0] w);
      @(posedge clk_i);
      #2;
      req_o = '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: w};
      @(posedge clk_i);
      #2;
      req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~w};
   endtask

   task automatic rd_reg(input logic [7:0] c, output logic [7:0] d);
      @(posedge clk_i);
      #2;
      req_o = '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 8'h00};
      @(posedge clk_i);
      #2;
      d = rdata_i;
      req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: 8'hFF};
   endtask
endmodule

/* File: sim/pse_port_control_regs_tb_top.sv */
`timescale 1ns/1ns
module pse_port_control_regs_tb_top
   import ppc_pkg::*;
   ;
   localparam int TK = 50;
   logic                   clk_i = 1'b0;
   logic                   rst_n_i = 1'b0;
   logic                   auto_pin = 1'b0;
   ppc_reg_req_t           req;
   logic [7:0]             rdata;
   ppc_sense_t [NPORT-1:0] sense = '0;
   logic                   osc_inv = 1'b0;
   logic                   int_pend = 1'b0;
   logic [NPORT-1:0]       pwr, det_req, cls_req, disf;
   logic                   oscillator_fault_flag, int_o;
   int                     n_mismatch = 0;
   int                     compares = 0;
   logic [31:0]            rs = 32'h0001_7FFB;
   logic [7:0]             v, c, d;
   logic [7:0]             tbl [6] = '{CMD_DISC_EN, CMD_DC_EN, CMD_TIMING, CMD_MASK, CMD_RESTART, 8'h15};
   logic [7:0]             pw_in [5] = '{8'h01, 8'h11, 8'h0F, 8'hF0, 8'h3C};
   logic [7:0]             pw_ex [5] = '{8'h01, 8'h00, 8'h0F, 8'h00, 8'h0C};

   always #10 clk_i = ~clk_i;

   pse_port_control_regs #(.TICK_CYC(TK)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .auto_pin_i(auto_pin), .reg_req_i(req),
      .reg_rdata_o(rdata), .sense_i(sense), .osc_invalid_i(osc_inv), .int_pending_i(int_pend),
      .port_power_o(pwr), .detect_req_o(det_req), .class_req_o(cls_req),
      .disconnect_fault_flag_o(disf), .oscillator_fault_flag_o(oscillator_fault_flag), .int_o(int_o));
   ppc_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction

   // readback expected after writing w to command a
   function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] w);
      case (a)
         CMD_DISC_EN, CMD_DC_EN: rb = w;
         CMD_TIMING: rb = w & 8'h3F;
         CMD_MASK: rb = w & 8'hA0;
         default: rb = 8'h00;
      endcase
   endfunction

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd_reg(a, v);
      chk($sformatf("reg %h", a), v, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask

   task automatic wms(input int n);
      cyc(n * TK);
   endtask

   task automatic wait_pwr(input logic [3:0] e, input int ms);
      for (int i = 0; i < ms * TK && pwr !== e; i++) cyc(1);
      chk("power wait", {4'h0, pwr}, {4'h0, e});
      if (pwr !== e) final_report();
   endtask

   task automatic do_reset(input logic a);
      auto_pin = a;
      rst_n_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #2;
      rst_n_i = 1'b1;
      cyc(10);
   endtask

   initial begin
      for (int a = 1; a >= 0; a--) begin
         do_reset(a[0]);
         rc(CMD_MODE, {8{a[0]}});
         rc(CMD_DISC_EN, {{4{a[0]}}, 4'h0});
         rc(CMD_DC_EN, {8{a[0]}});
         rc(CMD_TIMING, 8'h00);
         rc(CMD_MASK, 8'hA0);
         rc(CMD_RESTART, 8'h00);
      end
      $display("test reset values done");
      host_u.wr_reg(CMD_MODE, 8'h55);
      for (int i = 0; i < 12; i++) begin
         c = tbl[i % 6];
         d = rnd();
         host_u.wr_reg(c, d);
         rc(c, rb(c, d));
      end
      for (int m = 0; m < 4; m++) begin
         host_u.wr_reg(CMD_MODE, {4{m[1:0]}});
         rc(CMD_MODE, {4{m[1:0]}});
      end
      $display("test register access done");
      int_pend = 1'b1;
      host_u.wr_reg(CMD_MASK, 8'h00);
      chk("int_o", {7'h0, int_o}, 8'h00);
      host_u.wr_reg(CMD_MASK, 8'h80);
      chk("int_o", {7'h0, int_o}, 8'h01);
      int_pend = 1'b0;
      osc_inv = 1'b1;
      host_u.wr_reg(CMD_MASK, 8'h00);
      cyc(8);
      chk("osc flag", {7'h0, oscillator_fault_flag}, 8'h00);
      host_u.wr_reg(CMD_MASK, 8'h20);
      cyc(8);
      chk("osc flag", {7'h0, oscillator_fault_flag}, 8'h01);
      osc_inv = 1'b0;
      $display("test masks done");
      host_u.wr_reg(CMD_DC_EN, 8'h00);
      host_u.wr_reg(CMD_MODE, 8'h55);
      for (int i = 0; i < 5; i++) begin
         host_u.wr_reg(CMD_PWR_CMD, pw_in[i]);
         chk("power", {4'h0, pwr}, pw_ex[i]);
      end
      host_u.wr_reg(CMD_MODE, 8'h00);
      host_u.wr_reg(CMD_PWR_CMD, 8'h0F);
      cyc(3);
      chk("power", {4'h0, pwr}, 8'h00);
      $display("test power commands done");
      host_u.wr_reg(CMD_MODE, 8'h55);
      host_u.wr_reg(CMD_RESTART, 8'h00);
      rc(CMD_DC_EN, 8'h00);
      host_u.wr_reg(CMD_RESTART, 8'h01);
      chk("detect req", {4'h0, det_req}, 8'h01);
      sense[0].det_done = 1'b1;
      cyc(4);
      sense[0].det_done = 1'b0;
      cyc(4);
      chk("detect req", {4'h0, det_req}, 8'h00);
      rc(CMD_DC_EN, 8'h00);
      host_u.wr_reg(CMD_RESTART, 8'hF0);
      chk("class req", {4'h0, cls_req}, 8'h0F);
      host_u.wr_reg(CMD_MODE, 8'hAA);
      host_u.wr_reg(CMD_RESTART, 8'h0F);
      rc(CMD_DC_EN, 8'hFF);
      host_u.wr_reg(CMD_DC_EN, 8'h00);
      $display("test restart done");
      host_u.wr_reg(CMD_MODE, 8'h55);
      host_u.wr_reg(CMD_TIMING, 8'h15);
      host_u.wr_reg(CMD_DISC_EN, 8'h00);
      host_u.wr_reg(CMD_PWR_CMD, 8'h01);
      sense[0].ac_imp_high = 1'b1;
      wms(100);
      chk("power", {4'h0, pwr}, 8'h01);
      host_u.wr_reg(CMD_DISC_EN, 8'h10);
      wms(60);
      sense[0].ac_imp_high = 1'b0;
      cyc(10);
      sense[0].ac_imp_high = 1'b1;
      wms(85);
      chk("power", {4'h0, pwr}, 8'h01);
      wait_pwr(4'h0, 10);
      chk("disconnect flag", {4'h0, disf}, 8'h01);
      sense[0].ac_imp_high = 1'b0;
      host_u.wr_reg(CMD_PWR_CMD, 8'h10);
      $display("test disconnect done");
      sense[1].over_cut = 1'b1;
      host_u.wr_reg(CMD_PWR_CMD, 8'h02);
      wms(25);
      chk("power", {4'h0, pwr}, 8'h02);
      wait_pwr(4'h0, 10);
      sense[1].over_cut = 1'b0;
      wms(400);
      host_u.wr_reg(CMD_PWR_CMD, 8'h02);
      chk("power", {4'h0, pwr}, 8'h00);
      wms(100);
      host_u.wr_reg(CMD_PWR_CMD, 8'h02);
      chk("power", {4'h0, pwr}, 8'h02);
      wms(35);
      sense[1].over_cut = 1'b1;
      wms(25);
      chk("power", {4'h0, pwr}, 8'h02);
      wait_pwr(4'h0, 10);
      $display("test overcurrent done");
      final_report();
   end
endmodule
